// *** rtl/psr_pkg.sv ***
// Contract
// - Pad levels bits 9:0 sampled raw, unfiltered
// - Bit 15 low while power-good pulled low
// - Bit 14 low while alert pulled low
// - Bits 13:10 low per driven fault line
// - Address pin fields: 11 high, 10 float, 00 low
// - Bits 5,4 show run pin 1, 0
// - Bits 3:0 sensed fault line levels
// - Bus address is base plus offset 0-8
// - Respond to the computed bus address
// - Base address bit 7 reads zero
// - Maker identifier is fixed read-only code
// - Lot register holds factory lot number
// - Undischarged turn-on sets flag, pulls alert
// - Hold channel off until output discharged
// - Coefficient above 1.0 disables the check
// - Coefficient stored as 16-bit L11 value
// - Failed discharge may hold others via fault lines
// - Common bit 1 set while timebase held low
// - Common bit 0 follows write-protect pin
// - Common bits 7:2 read zero
package psr_pkg;

   localparam int CLK_PERIOD_NS = 4;
   localparam int SHARE_HOLD_US = 10;
   localparam int SHARE_HOLD_CYC =
      (SHARE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NCHAN = 8;
   localparam int NLINE = 4;

   localparam logic [7:0] CMD_PADS = 8'he5;
   localparam logic [7:0] CMD_BASE = 8'he6;
   localparam logic [7:0] CMD_ID = 8'he7;
   localparam logic [7:0] CMD_LOT = 8'he8;
   localparam logic [7:0] CMD_DISCH = 8'he9;
   localparam logic [7:0] CMD_COMMON = 8'hef;

   localparam logic [6:0] BASE_RST = 7'h5c;
   // L11 0.5: exponent -1, mantissa 1
   localparam logic [15:0] DISCH_RST = 16'hf801;
   localparam int L11_EXP_MSB = 15;
   localparam int L11_EXP_LSB = 11;
   localparam int L11_SIGN = 10;
   localparam logic [63:0] ONE_SCALED = 64'h0000_0000_0001_0000;

   localparam logic [1:0] ASEL_HIGH = 2'h3;
   localparam logic [1:0] ASEL_FLOAT = 2'h2;
   localparam logic [1:0] ASEL_LOW = 2'h0;
   localparam logic [3:0] ADDR_OFS_MAX = 4'h9;

   typedef struct packed {
      logic pgood_free;
      logic alert_free;
      logic [3:0] fault_free;
      logic [1:0] addr_pin1_state;
      logic [1:0] addr_pin0_state;
      logic run_pin_1;
      logic run_pin_0;
      logic [3:0] fault_lvl;
   } psr_pads_s;

   typedef struct packed {
      logic [5:0] rsvd;
      logic share_held;
      logic wp_high;
   } psr_common_s;

   typedef enum logic [2:0] {
      CH_OFF = 3'h1,
      CH_WAIT = 3'h2,
      CH_ON = 3'h4
   } psr_chan_e;

endpackage : psr_pkg

// *** rtl/psr_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_bank #(
   parameter logic [15:0] MAKER_ID = 16'h0a5a, // Arbitrary value
   parameter logic [7:0] LOT_NUMBER = 8'h01 // Arbitrary value
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Command port
   input wire logic [7:0] CMD_CODE,
   input wire logic CMD_RD,
   input wire logic CMD_WR,
   input wire logic [15:0] CMD_WDATA,
   output logic [15:0] CMD_RDATA,
   output logic CMD_DONE,
   output logic CMD_NACK,
   // Bus address
   input wire logic [6:0] BUS_ADDR,
   output logic [6:0] DEV_ADDR,
   output logic ADDR_MATCH,
   // Pads
   input wire logic PGOOD_PULL,
   input wire logic ALERT_PULL_EXT,
   output logic ALERT_O,
   output logic ALERT_OE,
   input wire logic [3:0] FAULT_I,
   output logic [3:0] FAULT_O,
   output logic [3:0] FAULT_OE,
   input wire logic [1:0] ADDR_PIN0_STATE,
   input wire logic [1:0] ADDR_PIN1_STATE,
   input wire logic RUN_PIN_0,
   input wire logic RUN_PIN_1,
   input wire logic SHARE_CLK_I,
   input wire logic WP_I,
   // Channels
   input wire logic [7:0] CHAN_ON_REQ,
   input wire logic [7:0][15:0] VOUT_MEAS,
   input wire logic [7:0][15:0] VOUT_CMD,
   input wire logic [3:0] FWD_MASK,
   input wire logic [3:0] HOLD_MASK,
   input wire logic CLEAR_FLAGS,
   output logic [7:0] CHAN_ON,
   output logic [7:0] DISCHARGE_FLAG
);

   ////////////////////////////////////////////////////////////////////
   psr_pkg::psr_pads_s pad_q;
   logic [6:0] base_q;
   logic [15:0] coef_q;
   logic [11:0] share_cnt_q;
   logic share_held_q;
   logic [3:0] addr_ofs;
   logic [7:0] above;
   logic [7:0] enter_wait;
   logic [7:0] waiting;
   logic disch_off;
   logic hold;
   psr_pkg::psr_chan_e st_q [8];

   // Scales x by the L11 coefficient, 16 fraction bits kept
   function automatic logic [63:0] l11_scale(input logic [15:0] x,
                                             input logic [15:0] c);
      logic [9:0] m;
      logic [4:0] sh;
      logic [63:0] p;
      // Negative coefficient acts as zero
      m = c[psr_pkg::L11_SIGN] ? 10'h000 : c[9:0];
      sh = {~c[psr_pkg::L11_EXP_MSB], c[psr_pkg::L11_EXP_MSB-1:
                                         psr_pkg::L11_EXP_LSB]};
      p = 64'(x) * 64'(m);
      return p << sh;
   endfunction : l11_scale

   function automatic logic [3:0] asel_weight(input logic [1:0] s);
      logic [3:0] w;
      case (s)
         psr_pkg::ASEL_HIGH: w = 4'h2;
         psr_pkg::ASEL_LOW: w = 4'h0;
         default: w = 4'h1; // Reserved code taken as floating
      endcase
      return w;
   endfunction : asel_weight

   ////////////////////////////////////////////////////////////////////
   // Raw pad capture, no deglitch so software sees true pin activity
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         pad_q <= '0;
      end else begin
         pad_q.pgood_free <= ~PGOOD_PULL;
         pad_q.alert_free <= ~ALERT_OE;
         pad_q.fault_free <= ~FAULT_OE;
         pad_q.addr_pin1_state <= ADDR_PIN1_STATE;
         pad_q.addr_pin0_state <= ADDR_PIN0_STATE;
         pad_q.run_pin_1 <= RUN_PIN_1;
         pad_q.run_pin_0 <= RUN_PIN_0;
         pad_q.fault_lvl <= FAULT_I;
      end
   end

   a_pad_raw_level: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      $past(NRST) |-> pad_q.fault_lvl == $past(FAULT_I))
      else $error("fault level readback wrong");

   a_alert_readback: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      ALERT_OE |=> !pad_q.alert_free)
      else $error("alert drive readback wrong");

   ////////////////////////////////////////////////////////////////////
   // Shared timebase held-low detector
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         share_cnt_q <= '0;
         share_held_q <= 1'b0;
      end else begin
         if (SHARE_CLK_I) begin
            share_cnt_q <= '0;
         end else if (share_cnt_q != 12'(psr_pkg::SHARE_HOLD_CYC)) begin
            share_cnt_q <= share_cnt_q + 12'h001;
         end
         share_held_q <= !SHARE_CLK_I &&
            share_cnt_q == 12'(psr_pkg::SHARE_HOLD_CYC);
      end
   end

   a_share_active: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      SHARE_CLK_I |=> !share_held_q [*2])
      else $error("timebase held while toggling");

   a_share_held: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      !SHARE_CLK_I && share_cnt_q == 12'(psr_pkg::SHARE_HOLD_CYC)
      |=> share_held_q)
      else $error("timebase low but not reported held");

   ////////////////////////////////////////////////////////////////////
   // Bus address
   assign addr_ofs = 4'(asel_weight(ADDR_PIN1_STATE) * 4'h3) +
                     asel_weight(ADDR_PIN0_STATE);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         DEV_ADDR <= psr_pkg::BASE_RST;
      end else begin
         DEV_ADDR <= base_q + 7'(addr_ofs);
      end
   end

   assign ADDR_MATCH = (BUS_ADDR == DEV_ADDR);

   a_addr_sum: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      $past(NRST) |-> DEV_ADDR == $past(base_q) + 7'($past(addr_ofs)))
      else $error("device address not base plus offset");

   ////////////////////////////////////////////////////////////////////
   // Command port: writes
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         base_q <= psr_pkg::BASE_RST;
         coef_q <= psr_pkg::DISCH_RST;
      end else if (CMD_WR) begin
         if (CMD_CODE == psr_pkg::CMD_BASE) begin
            base_q <= CMD_WDATA[6:0];
         end
         if (CMD_CODE == psr_pkg::CMD_DISCH) begin
            coef_q <= CMD_WDATA;
         end
      end
   end

   // Command port: reads, pure mux so reading never disturbs state
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CMD_RDATA <= '0;
      end else if (CMD_RD) begin
         case (CMD_CODE)
            psr_pkg::CMD_PADS: CMD_RDATA <= pad_q;
            psr_pkg::CMD_BASE: CMD_RDATA <= {9'h000, base_q};
            psr_pkg::CMD_ID: CMD_RDATA <= MAKER_ID;
            psr_pkg::CMD_LOT: CMD_RDATA <= {8'h00, LOT_NUMBER};
            psr_pkg::CMD_DISCH: CMD_RDATA <= coef_q;
            psr_pkg::CMD_COMMON: begin
               CMD_RDATA <= {8'h00, 6'h00, share_held_q, WP_I};
            end
            default: CMD_RDATA <= '0;
         endcase
      end else begin
         CMD_RDATA <= '0;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CMD_DONE <= 1'b0;
         CMD_NACK <= 1'b0;
      end else begin
         CMD_DONE <= CMD_RD | CMD_WR;
         CMD_NACK <= (CMD_RD && !(CMD_CODE inside {psr_pkg::CMD_PADS,
            psr_pkg::CMD_BASE, psr_pkg::CMD_ID, psr_pkg::CMD_LOT,
            psr_pkg::CMD_DISCH, psr_pkg::CMD_COMMON})) ||
            (CMD_WR && !(CMD_CODE inside {psr_pkg::CMD_BASE,
            psr_pkg::CMD_DISCH}));
      end
   end

   a_pgood_readback: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      ##2 CMD_RD && CMD_CODE == psr_pkg::CMD_PADS
      |=> CMD_RDATA[15] == !$past(PGOOD_PULL, 2))
      else $error("power-good readback wrong");

   a_base_rsvd: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_RD && CMD_CODE == psr_pkg::CMD_BASE
      |=> CMD_RDATA[15:7] == 9'h000 && CMD_DONE)
      else $error("base address bit 7 not zero");

   a_base_write: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_WR && CMD_CODE == psr_pkg::CMD_BASE
      |=> base_q == $past(CMD_WDATA[6:0]))
      else $error("base address write lost");

   a_id_fixed: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_RD && CMD_CODE == psr_pkg::CMD_ID
      |=> CMD_RDATA == MAKER_ID && !CMD_NACK)
      else $error("maker identifier wrong");

   a_id_write_nack: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_WR && CMD_CODE == psr_pkg::CMD_ID
      |=> CMD_NACK && CMD_DONE)
      else $error("write to identifier not refused");

   a_lot_fixed: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_RD && CMD_CODE == psr_pkg::CMD_LOT
      |=> CMD_RDATA == {8'h00, LOT_NUMBER} && !CMD_NACK)
      else $error("lot number wrong");

   a_common_bits: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_RD && CMD_CODE == psr_pkg::CMD_COMMON
      |=> CMD_RDATA[15:2] == 14'h0000 &&
          CMD_RDATA[0] == $past(WP_I))
      else $error("common status wrong");

   a_read_no_effect: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      CMD_RD && !CMD_WR |=> $stable(base_q) && $stable(coef_q))
      else $error("read changed a register");

   ////////////////////////////////////////////////////////////////////
   // Discharge check and channel turn-on
   assign disch_off =
      l11_scale(16'h0001, coef_q) > psr_pkg::ONE_SCALED;
   // Held off while an enabled fault line is low
   assign hold = |(HOLD_MASK & ~FAULT_I);

   for (genvar i = 0; i < psr_pkg::NCHAN; i++) begin : g_chan
      assign above[i] = {32'h0, VOUT_MEAS[i], 16'h0000} >=
                        l11_scale(VOUT_CMD[i], coef_q);
      assign waiting[i] = (st_q[i] == psr_pkg::CH_WAIT);
      assign enter_wait[i] = st_q[i] == psr_pkg::CH_OFF && CHAN_ON_REQ[i] &&
                             !hold && above[i] && !disch_off;

      always_ff @(posedge REF_CLK or negedge NRST) begin
         if (!NRST) begin
            st_q[i] <= psr_pkg::CH_OFF;
         end else begin
            case (st_q[i])
               psr_pkg::CH_OFF: begin
                  if (enter_wait[i]) begin
                     st_q[i] <= psr_pkg::CH_WAIT;
                  end else if (CHAN_ON_REQ[i] && !hold) begin
                     st_q[i] <= psr_pkg::CH_ON;
                  end
               end
               // Hold ignored here, else our own drive would deadlock us
               psr_pkg::CH_WAIT: begin
                  if (!CHAN_ON_REQ[i]) begin
                     st_q[i] <= psr_pkg::CH_OFF;
                  end else if (!above[i] || disch_off) begin
                     st_q[i] <= psr_pkg::CH_ON;
                  end
               end
               psr_pkg::CH_ON: begin
                  if (!CHAN_ON_REQ[i]) begin
                     st_q[i] <= psr_pkg::CH_OFF;
                  end
               end
               default: st_q[i] <= psr_pkg::CH_OFF;
            endcase
         end
      end

      // Set wins over clear
      always_ff @(posedge REF_CLK or negedge NRST) begin
         if (!NRST) begin
            DISCHARGE_FLAG[i] <= 1'b0;
         end else begin
            DISCHARGE_FLAG[i] <= enter_wait[i] ||
               (DISCHARGE_FLAG[i] && !CLEAR_FLAGS);
         end
      end

      assign CHAN_ON[i] = (st_q[i] == psr_pkg::CH_ON);

      a_wait_holds: assert property (
         @(posedge REF_CLK) disable iff (!NRST)
         st_q[i] == psr_pkg::CH_WAIT && above[i] && !disch_off
         |=> st_q[i] != psr_pkg::CH_ON)
         else $error("channel on before discharge");

      a_disable_check: assert property (
         @(posedge REF_CLK) disable iff (!NRST)
         st_q[i] == psr_pkg::CH_OFF && CHAN_ON_REQ[i] && !hold && disch_off
         |=> CHAN_ON[i] && !$rose(DISCHARGE_FLAG[i]))
         else $error("disabled check still blocked turn-on");

      a_flag_sticky: assert property (
         @(posedge REF_CLK) disable iff (!NRST)
         DISCHARGE_FLAG[i] && !CLEAR_FLAGS |=> DISCHARGE_FLAG[i])
         else $error("discharge flag lost without clear");

      a_hold_blocks: assert property (
         @(posedge REF_CLK) disable iff (!NRST)
         st_q[i] == psr_pkg::CH_OFF && hold |=> !CHAN_ON[i])
         else $error("channel turned on while held");
   end

   ////////////////////////////////////////////////////////////////////
   // Open-drain drives
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ALERT_OE <= 1'b0;
         FAULT_OE <= '0;
      end else begin
         ALERT_OE <= (|DISCHARGE_FLAG) | ALERT_PULL_EXT;
         FAULT_OE <= FWD_MASK & {4{|waiting}};
      end
   end

   assign ALERT_O = 1'b0;
   assign FAULT_O = 4'h0;

   a_disch_alert: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (|enter_wait) |=> ##1 ALERT_OE)
      else $error("discharge flag did not pull alert");

endmodule : psr_bank
`default_nettype wire

// *** tb/psr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_host (
   // Clock
   input wire logic clk,
   // Answer from the block
   input wire logic done,
   input wire logic nack,
   input wire logic [15:0] rdata,
   // Request to the block
   output logic [7:0] code,
   output logic rd,
   output logic wr,
   output logic [15:0] wdata
);
   initial begin
      code = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // Strobe is a one-cycle pulse, so it drops right after the take edge
   task automatic xfer(input logic w, input logic [7:0] c,
         input logic [15:0] d, output logic [15:0] q, output logic n,
         output logic ok);
      int k;
      k = 0;
      ok = 1'b0;
      q = 16'h0000;
      n = 1'b0;
      code <= c;
      wdata <= d;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      while (!ok && k < 4) begin
         @(posedge clk);
         k++;
         if (done === 1'b1) begin
            ok = 1'b1;
            q = rdata;
            n = nack;
         end
      end
   endtask : xfer
endmodule : psr_host
`default_nettype wire

// *** tb/psr_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_bank_tb;
   logic REF_CLK = 1'b0, NRST = 1'b0;
   logic done, nack, am, aoe, ao, rd, wr;
   logic pg = 1'b0, alx = 1'b0, rp0 = 1'b0, rp1 = 1'b0;
   logic shc = 1'b1, wp = 1'b0, clr = 1'b0;
   logic [7:0] code, con, flg, req = 8'h00;
   logic [15:0] wd, rdat, q, e;
   logic [6:0] dev, ex, bus = 7'h00;
   logic [3:0] fo, foe, fw, fext = 4'h0, fwd = 4'h0, hold = 4'h0;
   logic [1:0] a0 = 2'h0, a1 = 2'h0;
   logic [7:0][15:0] meas = '0, vcmd = {8{16'd1000}};
   int bad_count = 0, tests_run = 0, i, w;
   // Open-drain lines read low if either side pulls
   assign fw = ~(foe | fext);
   always #2 REF_CLK = ~REF_CLK;
   psr_host u_psr_host (.clk(REF_CLK), .done(done), .nack(nack),
      .rdata(rdat), .code(code), .rd(rd), .wr(wr), .wdata(wd));
   psr_bank u_psr_bank (.REF_CLK(REF_CLK), .NRST(NRST), .CMD_CODE(code),
      .CMD_RD(rd), .CMD_WR(wr), .CMD_WDATA(wd), .CMD_RDATA(rdat),
      .CMD_DONE(done), .CMD_NACK(nack), .BUS_ADDR(bus), .DEV_ADDR(dev),
      .ADDR_MATCH(am), .PGOOD_PULL(pg), .ALERT_PULL_EXT(alx),
      .ALERT_O(ao), .ALERT_OE(aoe), .FAULT_I(fw), .FAULT_O(fo),
      .FAULT_OE(foe), .ADDR_PIN0_STATE(a0), .ADDR_PIN1_STATE(a1),
      .RUN_PIN_0(rp0), .RUN_PIN_1(rp1), .SHARE_CLK_I(shc), .WP_I(wp),
      .CHAN_ON_REQ(req), .VOUT_MEAS(meas), .VOUT_CMD(vcmd),
      .FWD_MASK(fwd), .HOLD_MASK(hold), .CLEAR_FLAGS(clr),
      .CHAN_ON(con), .DISCHARGE_FLAG(flg));
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   // Expected data and refusal are worked out by the caller
   task automatic acc(input logic w, input logic [7:0] c,
         input logic [15:0] d, input logic [15:0] ed, input logic en);
      logic n, ok;
      u_psr_host.xfer(w, c, d, q, n, ok);
      if (!ok) begin
         $display("[FAIL] %0t no answer to command %h", $time, c);
         bad_count++;
         test_done();
      end
      chk(q, ed);
      chk({15'h0, n}, {15'h0, en});
   endtask : acc
   task automatic cyc(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask : cyc
   function automatic int ofs(input logic [1:0] s);
      return (s == 2'h3) ? 2 : ((s == 2'h0) ? 0 : 1);
   endfunction : ofs
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hc07c07af));
      cyc(5);
      NRST <= 1'b1;
      cyc(1);
      acc(0, 8'he6, 0, 16'h005c, 0);
      acc(0, 8'he9, 0, 16'hf801, 0);
      acc(0, 8'he8, 0, 16'h0001, 0);
      acc(1, 8'he7, 16'h1234, 0, 1);
      acc(0, 8'he7, 0, 16'h0a5a, 0);
      acc(1, 8'he5, 16'hffff, 0, 1);
      // Base plus pin offset, every pin pair
      for (i = 0; i < 3; i++) begin
         e = 16'($urandom_range(0, 118));
         acc(1, 8'he6, 16'hff80 | e, 0, 0);
         acc(0, 8'he6, 0, e, 0);
         for (w = 0; w < 16; w++) begin
            ex = 7'(e + ofs(w[3:2]) * 3 + ofs(w[1:0]));
            a1 <= w[3:2];
            a0 <= w[1:0];
            bus <= ex;
            cyc(3);
            chk({9'h0, dev}, {9'h0, ex});
            chk({15'h0, am}, 16'h0001);
            bus <= ex ^ 7'h01;
            cyc(1);
            chk({15'h0, am}, 16'h0000);
         end
      end
      // Random pad levels, no channel active
      for (i = 0; i < 8; i++) begin
         {pg, alx, rp0, rp1, wp, a0, a1, fext} <= 13'($urandom());
         cyc(2);
         e = {~pg, ~alx, 4'hf, a1, a0, rp1, rp0, ~fext};
         acc(0, 8'he5, 0, e, 0);
         acc(0, 8'hef, 0, {15'h0, wp}, 0);
      end
      {pg, alx, rp0, rp1, a0, a1, fext} <= 12'h000;
      fwd <= 4'ha;
      meas <= {8{16'd600}};
      req <= 8'h04;
      cyc(4);
      chk({8'h0, flg}, 16'h0004);
      chk({8'h0, con}, 16'h0000);
      chk({12'h0, foe}, 16'h000a);
      chk({15'h0, aoe}, 16'h0001);
      chk({11'h0, ao, fo}, 16'h0000);
      acc(0, 8'he5, 0, 16'h9405, 0);
      acc(0, 8'he5, 0, 16'h9405, 0);
      meas <= {8{16'd400}};
      cyc(3);
      chk({8'h0, con}, 16'h0004);
      chk({8'h0, flg}, 16'h0004);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      req <= 8'h00;
      fwd <= 4'h0;
      cyc(3);
      chk({8'h0, flg | con}, 16'h0000);
      // Coefficient 2.0 lets an undecayed output back on
      acc(1, 8'he9, 16'h0801, 0, 0);
      acc(0, 8'he9, 0, 16'h0801, 0);
      meas <= {8{16'd600}};
      req <= 8'h08;
      cyc(3);
      chk({flg, con}, 16'h0008);
      req <= 8'h00;
      meas <= '0;
      hold <= 4'h1;
      fext <= 4'h1;
      cyc(1);
      req <= 8'h10;
      cyc(4);
      chk({8'h0, con}, 16'h0000);
      fext <= 4'h0;
      cyc(3);
      chk({8'h0, con}, 16'h0010);
      shc <= 1'b0;
      cyc(2510);
      acc(0, 8'hef, 0, {14'h0, 1'b1, wp}, 0);
      shc <= 1'b1;
      cyc(3);
      acc(0, 8'hef, 0, {15'h0, wp}, 0);
      // Mid-run reset must bring both writable registers back
      NRST <= 1'b0;
      cyc(5);
      NRST <= 1'b1;
      cyc(1);
      acc(0, 8'he6, 0, {9'h0, psr_pkg::BASE_RST}, 0);
      acc(0, 8'he9, 0, psr_pkg::DISCH_RST, 0);
      chk({9'h0, dev}, {9'h0, psr_pkg::BASE_RST});
      test_done();
   end
endmodule : psr_bank_tb
`default_nettype wire
